/* File: hw/gpcmd_cfg.svh */
`ifndef GPCMD_CFG_SVH
`define GPCMD_CFG_SVH
`define INS_GET_GLOBAL 8'h0a
`define INS_STORE_GLOBAL 8'h0b
`define INS_RESTORE_GLOBAL 8'h0c
`define INS_SET_GLOBAL 8'h09
`define INS_REF_SEARCH 8'h0d
`define BANK_MODULE 8'h00
`define BANK_USER 8'h02
`define BANK_IRQ 8'h03
`define RFS_START 8'h00
`define RFS_STOP 8'h01
`define RFS_STATUS 8'h02
`define NUM_MOTORS 8'h06
`define ST_OK 8'h64
`define ST_BAD_CHECKSUM 8'h01
`define ST_BAD_INSTR 8'h02
`define ST_BAD_TYPE 8'h03
`define ST_BAD_VALUE 8'h04
`define FRAME_LAST 4'h8
`define VALUE_LAST 4'h7
`define VALUE_FIRST 4'h4
`define ZERO32 32'h0000_0000
`define HOST_ADDR_DEFAULT 8'h02
`define MODULE_ADDR_DEFAULT 8'h01
`endif

/* File: hw/gpcmd_pkg.sv */
package gpcmd_pkg;
  typedef enum logic [2:0] {
    st_boot,
    st_boot_wait,
    st_rx,
    st_exec,
    st_nv_wait,
    st_reply
  } gpcmd_state_t;
endpackage : gpcmd_pkg

/* File: hw/gp_var_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// 1024 x 32 parameter store, four banks of 256 words, one write port, registered read data
module gp_var_mem (
  // Clock
  input wire logic i_clk,
  // Access
  input wire logic i_we,
  input wire logic [9:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:1023];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule : gp_var_mem
`default_nettype wire

/* File: hw/global_param_refsearch_cmds.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpcmd_cfg.svh"
// Frame-level command interpreter for global parameters and reference search
module global_param_refsearch_cmds
  import gpcmd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Incoming frame bytes
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  output logic o_rx_ready,
  // Mode: 1 = standalone program, 0 = direct host
  input wire logic i_standalone,
  // Reply
  output logic o_reply_valid,
  input wire logic i_reply_ready,
  output logic [7:0] o_reply_status,
  output logic [7:0] o_reply_instr,
  output logic [31:0] o_reply_value,
  // Accumulator of the standalone program
  output logic [31:0] o_accu,
  // Non-volatile memory port
  output logic o_nv_req,
  output logic o_nv_write,
  output logic [7:0] o_nv_addr,
  output logic [31:0] o_nv_wdata,
  input wire logic i_nv_done,
  input wire logic [31:0] i_nv_rdata,
  // Reference search engine per motor
  output logic [5:0] o_rfs_start,
  output logic [5:0] o_rfs_stop,
  input wire logic [5:0] i_rfs_busy
);
  gpcmd_state_t state;
  gpcmd_state_t next_state;
  logic [7:0] frame [0:7];
  logic [3:0] idx;
  logic [7:0] sum;
  logic [7:0] boot_var;
  logic boot_last;
  logic [31:0] mem_rdata;
  logic [5:0] busy_s1;
  logic [5:0] busy_s2;
  logic [7:0] instr;
  logic [7:0] ptype;
  logic [7:0] bank;
  logic [31:0] value;
  logic bank_ok;
  logic motor_ok;
  logic is_user;
  logic [2:0] motor;
  logic csum_ok;
  logic nv_cmd;
  logic [7:0] user_bank;

  assign instr = frame[1];
  assign ptype = frame[2];
  assign bank = frame[3];
  assign value = {frame[4], frame[5], frame[6], frame[7]};
  assign motor = bank[2:0];
  assign bank_ok = (bank == `BANK_MODULE) || (bank == `BANK_USER) || (bank == `BANK_IRQ);
  assign is_user = (bank == `BANK_USER);
  assign motor_ok = bank < `NUM_MOTORS;
  assign o_rx_ready = (state == st_rx);

  // Memory map: bank in the top bits, type below
  logic mem_we;
  logic [9:0] mem_addr;
  logic [31:0] mem_wdata;
  logic set_cmd;
  assign set_cmd = (state == st_exec) && (instr == `INS_SET_GLOBAL) && bank_ok && csum_ok;
  // commands that wait for the non-volatile memory
  assign nv_cmd = csum_ok && (((instr == `INS_SET_GLOBAL) && (bank == `BANK_MODULE))
                || (((instr == `INS_STORE_GLOBAL) || (instr == `INS_RESTORE_GLOBAL)) && is_user));
  assign user_bank = `BANK_USER;
  assign mem_we = ((state == st_boot_wait) && i_nv_done)
                || ((state == st_nv_wait) && i_nv_done && !o_nv_write)
                || set_cmd;
  assign mem_addr = (state == st_boot_wait) ? {user_bank[1:0], boot_var}
                  : {bank[1:0], ptype};
  assign mem_wdata = (state == st_exec) ? value : i_nv_rdata;

  gp_var_mem u_mem (
    .i_clk(i_clk),
    .i_we(mem_we),
    .i_addr(mem_addr),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  // Two stages on the engine busy flags, they are another block's timing
  always_ff @(posedge i_clk) begin
    busy_s1 <= i_rfs_busy;
    busy_s2 <= busy_s1;
  end

  assign boot_last = (boot_var == 8'hff);

  always_comb begin
    next_state = state;
    case (state)
      st_boot: next_state = st_boot_wait;
      st_boot_wait: if (i_nv_done) next_state = boot_last ? st_rx : st_boot;
      st_rx: if (i_rx_valid && idx == `FRAME_LAST) next_state = st_exec;
      // The request flop is only set on leaving exec, so decide from the command itself
      st_exec: next_state = nv_cmd ? st_nv_wait : st_reply;
      st_nv_wait: if (i_nv_done) next_state = st_reply;
      st_reply: if (i_standalone || (o_reply_valid && i_reply_ready)) next_state = st_rx;
      default: next_state = st_rx;
    endcase
  end

  // Byte collection and checksum accumulation
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      idx <= 4'h0;
      sum <= 8'h00;
    end else if (state == st_rx && i_rx_valid) begin
      if (idx == `FRAME_LAST) begin
        idx <= 4'h0;
      end else begin
        frame[idx[2:0]] <= i_rx_byte;
        idx <= idx + 4'h1;
        // Restart on the first byte so the sum survives into execution
        sum <= (idx == 4'h0) ? i_rx_byte : sum + i_rx_byte;
      end
    end
  end

  logic [7:0] rx_csum;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_csum <= 8'h00;
    end else if (state == st_rx && i_rx_valid && idx == `FRAME_LAST) begin
      rx_csum <= i_rx_byte;
    end
  end
  assign csum_ok = (rx_csum == sum);

  logic [7:0] status;
  logic get_pending;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= st_boot;
      boot_var <= 8'h00;
      status <= `ST_OK;
      get_pending <= 1'b0;
      o_nv_req <= 1'b0;
      o_nv_write <= 1'b0;
      o_nv_addr <= 8'h00;
      o_nv_wdata <= `ZERO32;
      o_rfs_start <= 6'h00;
      o_rfs_stop <= 6'h00;
      o_accu <= `ZERO32;
      o_reply_valid <= 1'b0;
      o_reply_status <= 8'h00;
      o_reply_instr <= 8'h00;
      o_reply_value <= `ZERO32;
    end else begin
      state <= next_state;
      // Pending read lasts one cycle, or it would overwrite later replies
      get_pending <= 1'b0;
      o_nv_req <= 1'b0;
      o_rfs_start <= 6'h00;
      o_rfs_stop <= 6'h00;
      if (state == st_boot) begin
        o_nv_req <= 1'b1;
        o_nv_write <= 1'b0;
        o_nv_addr <= boot_var;
      end
      if (state == st_boot_wait && i_nv_done) begin
        boot_var <= boot_var + 8'h01;
      end
      if (state == st_exec) begin
        get_pending <= 1'b0;
        o_reply_value <= `ZERO32;
        if (!csum_ok) begin
          status <= `ST_BAD_CHECKSUM;
        end else begin
          status <= `ST_OK;
          case (instr)
            `INS_GET_GLOBAL: begin
              // read goes through the registered memory port
              if (bank_ok) get_pending <= 1'b1;
              else status <= `ST_BAD_VALUE;
            end
            `INS_SET_GLOBAL: begin
              // bank 0 written through to non-volatile memory
              if (!bank_ok) status <= `ST_BAD_VALUE;
              else if (bank == `BANK_MODULE) begin
                o_nv_req <= 1'b1;
                o_nv_write <= 1'b1;
                o_nv_addr <= ptype;
                o_nv_wdata <= value;
              end
            end
            `INS_STORE_GLOBAL: begin
              // user variable written to non-volatile memory
              if (!is_user) status <= `ST_BAD_VALUE;
              else begin
                o_nv_req <= 1'b1;
                o_nv_write <= 1'b1;
                o_nv_addr <= ptype;
                o_nv_wdata <= mem_rdata;
              end
            end
            `INS_RESTORE_GLOBAL: begin
              if (!is_user) status <= `ST_BAD_VALUE;
              else begin
                o_nv_req <= 1'b1;
                o_nv_write <= 1'b0;
                o_nv_addr <= ptype;
              end
            end
            `INS_REF_SEARCH: begin
              if (!motor_ok) status <= `ST_BAD_VALUE;
              else if (ptype == `RFS_START) o_rfs_start[motor] <= 1'b1;
              else if (ptype == `RFS_STOP) o_rfs_stop[motor] <= 1'b1;
              else if (ptype == `RFS_STATUS) begin
                o_reply_value <= {31'h0, busy_s2[motor]};
                if (i_standalone) o_accu <= {31'h0, busy_s2[motor]};
              end else status <= `ST_BAD_TYPE;
            end
            default: status <= `ST_BAD_INSTR;
          endcase
        end
      end
      if (get_pending) begin
        // value read goes to the reply
        o_reply_value <= mem_rdata;
        if (i_standalone) o_accu <= mem_rdata;
      end
      if (state == st_reply && !o_reply_valid && !i_standalone) begin
        o_reply_valid <= 1'b1;
        o_reply_status <= status;
        o_reply_instr <= instr;
      end else if (o_reply_valid && i_reply_ready) begin
        o_reply_valid <= 1'b0;
      end
    end
  end
endmodule : global_param_refsearch_cmds
`default_nettype wire

/* File: bench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Byte handshake
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_byte
);
  initial begin
    o_valid = 1'b0;
    o_byte = 8'h00;
  end
  task automatic send(input logic [63:0] body, input logic bad, output logic ok);
    logic [7:0] sum;
    logic got;
    int n;
    sum = 8'h00;
    ok = 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(negedge i_clk);
      o_valid = 1'b1;
      o_byte = (i < 8) ? body[63 - 8 * i -: 8] : sum + {7'h00, bad};
      sum = sum + o_byte;
      n = 0;
      do begin
        @(posedge i_clk);
        got = i_ready;
        n++;
      end while (got !== 1'b1 && n < 2000);
      if (got !== 1'b1) begin
        ok = 1'b0;
      end
    end
    @(negedge i_clk);
    o_valid = 1'b0;
    // A released line must not look like a fresh byte
    o_byte = ~o_byte;
  endtask : send
endmodule : host_model
`default_nettype wire

/* File: bench/gp_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module gp_checker (
  // Watched ports
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_standalone,
  input wire logic o_rx_ready,
  input wire logic o_reply_valid,
  input wire logic i_reply_ready,
  input wire logic [7:0] o_reply_status,
  input wire logic o_nv_req,
  input wire logic o_nv_write,
  input wire logic i_nv_done,
  input wire logic [5:0] o_rfs_start,
  input wire logic [5:0] o_rfs_stop
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic booted;
  // Boot reloads end once the receiver first opens
  always_ff @(posedge i_clk) begin
    booted <= i_rst_n & (booted | o_rx_ready);
  end
  sequence ok_reply;
    o_reply_valid && o_reply_status == 8'h64;
  endsequence
  a_reply_held: assert property (o_reply_valid && !i_reply_ready |=> o_reply_valid && $stable(o_reply_status))
    else $error("reply dropped early");
  a_standalone_quiet: assert property (o_reply_valid |-> !i_standalone)
    else $error("reply in standalone mode");
  a_rx_closed: assert property (o_reply_valid |-> !o_rx_ready)
    else $error("receiver open during reply");
  a_start_pulse: assert property (o_rfs_start != 6'h00 |-> $onehot(o_rfs_start) ##1 o_rfs_start == 6'h00)
    else $error("bad start pulse");
  a_stop_pulse: assert property (o_rfs_stop != 6'h00 |-> $onehot(o_rfs_stop) ##1 o_rfs_stop == 6'h00)
    else $error("bad stop pulse");
  a_start_stop_ok: assert property ((o_rfs_start | o_rfs_stop) != 6'h00 && !i_standalone |-> ##2 ok_reply)
    else $error("search command reply wrong");
  a_nv_answer: assert property (booted && i_nv_done && !i_standalone |-> ##2 ok_reply)
    else $error("memory command reply wrong");
  a_boot_reads: assert property (!booted && o_nv_req |-> !o_nv_write)
    else $error("write during boot reload");
  a_nv_single: assert property (o_nv_req |=> !o_nv_req)
    else $error("memory request too long");
endmodule : gp_checker
bind global_param_refsearch_cmds gp_checker u_chk (.i_clk, .i_rst_n, .i_standalone, .o_rx_ready, .o_reply_valid,
  .i_reply_ready, .o_reply_status, .o_nv_req, .o_nv_write, .i_nv_done, .o_rfs_start, .o_rfs_stop);
`default_nettype wire

/* File: bench/tb_global_param_refsearch_cmds.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_global_param_refsearch_cmds;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_standalone = 1'b0;
  logic i_reply_ready = 1'b0;
  logic i_nv_done = 1'b0;
  logic [31:0] i_nv_rdata = 32'h0;
  logic [5:0] i_rfs_busy = 6'h00;
  logic i_rx_valid, o_rx_ready, o_reply_valid, o_nv_req, o_nv_write;
  logic [7:0] i_rx_byte, o_reply_status, o_reply_instr, o_nv_addr, nv_at;
  logic [31:0] o_reply_value, o_accu, o_nv_wdata;
  logic [5:0] o_rfs_start, o_rfs_stop;
  logic [31:0] nvm [256];
  logic [2:0] nv_pipe = 3'h0;
  int bad_count = 0;
  int n_compared = 0;
  int nv_writes = 0;
  always #2.5 i_clk = ~i_clk;
  global_param_refsearch_cmds dut (.i_clk, .i_rst_n, .i_rx_valid, .i_rx_byte, .o_rx_ready, .i_standalone,
    .o_reply_valid, .i_reply_ready, .o_reply_status, .o_reply_instr, .o_reply_value, .o_accu, .o_nv_req,
    .o_nv_write, .o_nv_addr, .o_nv_wdata, .i_nv_done, .i_nv_rdata, .o_rfs_start, .o_rfs_stop, .i_rfs_busy);
  host_model host (.i_clk, .i_ready(o_rx_ready), .o_valid(i_rx_valid), .o_byte(i_rx_byte));
  // Slow memory and search engines; idle read data keeps toggling
  always @(negedge i_clk) begin
    nv_pipe <= {nv_pipe[1:0], o_nv_req};
    i_nv_done <= nv_pipe[1];
    i_nv_rdata <= nv_pipe[1] ? nvm[nv_at] : ~i_nv_rdata;
    i_rfs_busy <= (i_rfs_busy | o_rfs_start) & ~o_rfs_stop;
    if (o_nv_req) begin
      nv_at <= o_nv_addr;
      if (o_nv_write) begin
        nvm[o_nv_addr] <= o_nv_wdata;
        nv_writes <= nv_writes + 1;
      end
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmd(input logic [7:0] ins, typ, bank, input logic [31:0] val, input logic bad,
    input logic [7:0] est, output logic [31:0] v);
    logic ok;
    int n;
    host.send({8'h01, ins, typ, bank, val}, bad, ok);
    n = 0;
    while (o_reply_valid !== 1'b1 && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
    if (ok !== 1'b1 || n >= 3000) begin
      chk("reply wait", 32'h1, 32'h0);
      tally_and_finish();
    end
    // Leave ready low one cycle so the reply must hold
    @(negedge i_clk);
    v = o_reply_value;
    chk("status", {24'h0, est}, {24'h0, o_reply_status});
    chk("reply instr", {24'h0, ins}, {24'h0, o_reply_instr});
    i_reply_ready = 1'b1;
    @(negedge i_clk);
    i_reply_ready = 1'b0;
  endtask : cmd
  task automatic t_user_vars();
    logic [31:0] v;
    cmd(8'h0a, 8'h05, 8'h02, 32'h0, 1'b0, 8'h64, v);
    chk("boot value", 32'h1000_0005, v);
    cmd(8'h09, 8'h07, 8'h02, 32'hdead_beef, 1'b0, 8'h64, v);
    cmd(8'h0b, 8'h07, 8'h02, 32'h0, 1'b0, 8'h64, v);
    chk("stored word", 32'hdead_beef, nvm[7]);
    cmd(8'h09, 8'h07, 8'h02, 32'h11, 1'b0, 8'h64, v);
    cmd(8'h0c, 8'h07, 8'h02, 32'h0, 1'b0, 8'h64, v);
    cmd(8'h0a, 8'h07, 8'h02, 32'h0, 1'b0, 8'h64, v);
    chk("restored value", 32'hdead_beef, v);
  endtask : t_user_vars
  task automatic t_banks();
    logic [31:0] v;
    logic ok;
    int w0;
    w0 = nv_writes;
    cmd(8'h09, 8'h42, 8'h00, 32'h3, 1'b0, 8'h64, v);
    chk("auto commit", 32'h1, 32'(nv_writes - w0));
    cmd(8'h0a, 8'h42, 8'h00, 32'h0, 1'b0, 8'h64, v);
    chk("bank0 value", 32'h3, v);
    cmd(8'h0a, 8'h01, 8'h03, 32'h0, 1'b0, 8'h64, v);
    cmd(8'h0a, 8'h01, 8'h01, 32'h0, 1'b0, 8'h04, v);
    cmd(8'h0a, 8'h01, 8'h02, 32'h0, 1'b1, 8'h01, v);
    cmd(8'h09, 8'h07, 8'h02, 32'h55, 1'b1, 8'h01, v);
    cmd(8'h0b, 8'h07, 8'h00, 32'h0, 1'b0, 8'h04, v);
    @(negedge i_clk);
    i_standalone = 1'b1;
    host.send({8'h01, 8'h0a, 8'h07, 8'h02, 32'h0}, 1'b0, ok);
    chk("standalone frame", 32'h1, {31'h0, ok});
    repeat (8) @(negedge i_clk);
    chk("accumulator", 32'hdead_beef, o_accu);
    i_standalone = 1'b0;
  endtask : t_banks
  task automatic t_ref_search();
    logic [31:0] v;
    for (int m = 0; m < 6; m += 5) begin
      cmd(8'h0d, 8'h00, 8'(m), 32'h0, 1'b0, 8'h64, v);
      chk("engine started", 32'h1 << m, {26'h0, i_rfs_busy});
      repeat (3) @(negedge i_clk);
      // one query per step, no polling loop
      cmd(8'h0d, 8'h02, 8'(m), 32'h0, 1'b0, 8'h64, v);
      chk("search busy", 32'h1, v);
      cmd(8'h0d, 8'h01, 8'(m), 32'h0, 1'b0, 8'h64, v);
      repeat (3) @(negedge i_clk);
      cmd(8'h0d, 8'h02, 8'(m), 32'h0, 1'b0, 8'h64, v);
      chk("search idle", 32'h0, v);
    end
    cmd(8'h0d, 8'h03, 8'h00, 32'h0, 1'b0, 8'h03, v);
    cmd(8'h0d, 8'h00, 8'h06, 32'h0, 1'b0, 8'h04, v);
    cmd(8'h20, 8'h00, 8'h00, 32'h0, 1'b0, 8'h02, v);
  endtask : t_ref_search
  initial begin
    int n;
    for (int i = 0; i < 256; i++) begin
      nvm[i] = 32'h1000_0000 + i;
    end
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    n = 0;
    while (o_rx_ready !== 1'b1 && n < 5000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 5000) begin
      chk("boot reload", 32'h1, 32'h0);
      tally_and_finish();
    end
    t_user_vars();
    t_banks();
    t_ref_search();
    tally_and_finish();
  end
endmodule : tb_global_param_refsearch_cmds
`default_nettype wire
